// file: pdsc_power_ctrl.v
// Power domain sequencing and sleep mode control
`timescale 1ns/10ps
`include "pdsc_consts.vh"
module pdsc_power_ctrl (
  input  wire                          i_ref_clk,
  input  wire                          i_rstn,
  input  wire                          i_ce,
  input  wire                          i_sleep_deep_bit,
  input  wire                          i_core_sleeping,
  input  wire                          i_wake_irq,
  input  wire                          i_retain_system_ram,
  input  wire                          i_reset_after_wake,
  input  wire                          i_per_en,
  input  wire                          i_rad_en,
  input  wire [`PDSC_RR_N-1:0]         i_rr_en,
  input  wire                          i_nwords_wr,
  input  wire [`PDSC_NWORDS_W-1:0]     i_nwords_wdata,
  input  wire                          i_rad_keep_wr,
  input  wire [`PDSC_RAD_KEEP_W-1:0]   i_rad_keep_wdata,
  input  wire                          i_freeze_wr,
  input  wire                          i_freeze_wdata,
  input  wire                          i_emap_wr,
  input  wire                          i_emap_wdata,
  input  wire                          i_mirror_done,
  output wire                          o_always_on_domain,
  output wire                          o_system_domain,
  output wire                          o_peripheral_domain,
  output wire                          o_debug_domain,
  output wire                          o_radio_domain,
  output wire [`PDSC_RR_N-1:0]         o_retention_ram_domains,
  output wire                          o_system_ram_domain,
  output wire                          o_iso,
  output wire                          o_sysram_access_en,
  output wire                          o_analog_en,
  output wire                          o_periph_regs_clear,
  output wire                          o_mirror_start,
  output wire [`PDSC_NWORDS_W-1:0]     o_mirror_word_count,
  output wire [`PDSC_RAD_KEEP_W-1:0]   o_radio_control_two,
  output wire                          o_debug_freeze_enable,
  output wire                          o_exchange_memory_map,
  output wire                          o_hw_reset,
  output reg  [1:0]                    o_mode
);
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  reg [1:0] sd_sync_ff;
  reg [1:0] slp_sync_ff;
  reg [1:0] wk_sync_ff;
  always @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sd_sync_ff  <= 2'h0;
      slp_sync_ff <= 2'h0;
      wk_sync_ff  <= 2'h0;
    end else if (i_ce) begin
      sd_sync_ff  <= {sd_sync_ff[0], i_sleep_deep_bit};
      slp_sync_ff <= {slp_sync_ff[0], i_core_sleeping};
      wk_sync_ff  <= {wk_sync_ff[0], i_wake_irq};
    end
  end
  wire sleep_deep = sd_sync_ff[1];
  wire sleeping   = slp_sync_ff[1];
  wire wake       = wk_sync_ff[1];

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  reg [2:0]              state_ff;
  reg [2:0]              nxt_state;
  reg [`PDSC_CNT_W-1:0]  cnt_ff;
  reg [`PDSC_CNT_W-1:0]  nxt_cnt;
  reg                    keep_sr_ff;
  reg                    nxt_keep_sr;
  reg                    rst_pulse_ff;
  reg                    nxt_rst_pulse;
  wire cnt_done = (cnt_ff == {`PDSC_CNT_W{1'b0}});
  localparam integer           SETTLE_I = `PDSC_SETTLE_CYC;
  localparam [`PDSC_CNT_W-1:0] SETTLE   = SETTLE_I[`PDSC_CNT_W-1:0];

  always @* begin
    nxt_state     = state_ff;
    nxt_cnt       = (cnt_ff != {`PDSC_CNT_W{1'b0}}) ? cnt_ff - 1'b1 : cnt_ff;
    nxt_keep_sr   = keep_sr_ff;
    nxt_rst_pulse = 1'b0;
    case (state_ff)
      `PDSC_ST_ACTIVE: begin
        if (sleeping && sleep_deep) begin
          nxt_keep_sr = i_retain_system_ram;
          nxt_state   = `PDSC_ST_ISO;
          nxt_cnt     = SETTLE;
        end
      end
      `PDSC_ST_ISO: begin
        if (cnt_done) begin
          nxt_state = `PDSC_ST_OFF;
          nxt_cnt   = SETTLE;
        end
      end
      `PDSC_ST_OFF: begin
        if (cnt_done) begin
          nxt_state = `PDSC_ST_SLEEP;
        end
      end
      `PDSC_ST_SLEEP: begin
        if (wake) begin
          nxt_state = `PDSC_ST_PWRUP;
          nxt_cnt   = SETTLE;
        end
      end
      `PDSC_ST_PWRUP: begin
        if (cnt_done) begin
          nxt_state = `PDSC_ST_RELEASE;
          nxt_cnt   = SETTLE;
        end
      end
      `PDSC_ST_RELEASE: begin
        if (cnt_done) begin
          if (i_reset_after_wake) begin
            nxt_rst_pulse = 1'b1;
            nxt_state     = `PDSC_ST_ACTIVE;
          end else if (!keep_sr_ff) begin
            nxt_state = `PDSC_ST_MIRROR;
          end else begin
            nxt_state = `PDSC_ST_ACTIVE;
          end
        end
      end
      `PDSC_ST_MIRROR: begin
        if (i_mirror_done) begin
          nxt_state = `PDSC_ST_ACTIVE;
        end
      end
      default: begin
        nxt_state = `PDSC_ST_ACTIVE;
      end
    endcase
  end

  always @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_ff     <= `PDSC_ST_ACTIVE;
      cnt_ff       <= {`PDSC_CNT_W{1'b0}};
      keep_sr_ff   <= 1'b0;
      rst_pulse_ff <= 1'b0;
    end else if (i_ce) begin
      state_ff     <= nxt_state;
      cnt_ff       <= nxt_cnt;
      keep_sr_ff   <= nxt_keep_sr;
      rst_pulse_ff <= nxt_rst_pulse;
    end
  end

  // ----------------------------------------
  // Domain outputs
  // ----------------------------------------
  wire gated = (state_ff == `PDSC_ST_OFF) || (state_ff == `PDSC_ST_SLEEP) ||
               (state_ff == `PDSC_ST_PWRUP);
  wire iso_on = gated || (state_ff == `PDSC_ST_ISO) || (state_ff == `PDSC_ST_RELEASE);
  assign o_always_on_domain = 1'b1;
  assign o_system_domain = !gated;
  assign o_debug_domain = !gated;
  assign o_peripheral_domain = i_per_en;
  assign o_radio_domain      = i_rad_en;
  genvar g;
  generate
    for (g = 0; g < `PDSC_RR_N; g = g + 1) begin : g_rr
      assign o_retention_ram_domains[g] = i_rr_en[g];
    end
  endgenerate
  assign o_system_ram_domain = !gated || keep_sr_ff;
  assign o_sysram_access_en = !iso_on && (state_ff != `PDSC_ST_MIRROR);
  assign o_iso = iso_on;
  assign o_analog_en = !gated;
  assign o_periph_regs_clear = !i_per_en;
  assign o_mirror_start = (state_ff == `PDSC_ST_RELEASE) && cnt_done &&
                          !i_reset_after_wake && !keep_sr_ff;
  assign o_hw_reset = rst_pulse_ff;

  always @* begin
    if (!gated) begin
      o_mode = sleeping ? `PDSC_MODE_SLEEP : `PDSC_MODE_ACTIVE;
    end else begin
      o_mode = keep_sr_ff ? `PDSC_MODE_EXT : `PDSC_MODE_DEEP;
    end
  end

  // ----------------------------------------
  // Retained registers
  // ----------------------------------------
  // word count retained
  pdsc_keep_reg #(.W(`PDSC_NWORDS_W)) u_nwords (
    .i_ref_clk (i_ref_clk),
    .i_rstn    (i_rstn),
    .i_ce      (i_ce),
    .i_wr      (i_nwords_wr),
    .i_wdata   (i_nwords_wdata),
    .o_rdata   (o_mirror_word_count)
  );
  pdsc_keep_reg #(.W(`PDSC_RAD_KEEP_W + 2)) u_fields (
    .i_ref_clk (i_ref_clk),
    .i_rstn    (i_rstn),
    .i_ce      (i_ce),
    .i_wr      (i_rad_keep_wr | i_freeze_wr | i_emap_wr),
    .i_wdata   ({i_rad_keep_wr ? i_rad_keep_wdata : o_radio_control_two,
                 i_freeze_wr ? i_freeze_wdata : o_debug_freeze_enable,
                 i_emap_wr ? i_emap_wdata : o_exchange_memory_map}),
    .o_rdata   ({o_radio_control_two, o_debug_freeze_enable, o_exchange_memory_map})
  );
endmodule // pdsc_power_ctrl

// file: pdsc_consts.vh
// Constants for the power domain and sleep controller
// Notes on behaviour
// - Always-on domain powered in every mode
// - System domain on except in gated sleep
// - Plain sleep: no gating, programmed enables
// - Extended sleep keeps always-on, retention, system RAM
// - Deep sleep loses system RAM, mirror on wake unless reset-after-wake set
// - Hardware gates system, debug; system RAM per mode
// - Hardware disables analog blocks in gated sleep
// - Four retention banks gated independently
// - Always-on registers retained through sleep
// - Peripheral registers lost on power down
// - Mirror word count retained through sleep
// - Only listed radio/system fields retained
// - Debug domain switched off in gated sleep
// - Mirror engine copies words on wake
// - Reset-after-wake bit forces cold start
`ifndef PDSC_CONSTS_VH
`define PDSC_CONSTS_VH
`define PDSC_ST_ACTIVE   3'h0
`define PDSC_ST_ISO      3'h1
`define PDSC_ST_OFF      3'h2
`define PDSC_ST_SLEEP    3'h3
`define PDSC_ST_PWRUP    3'h4
`define PDSC_ST_RELEASE  3'h5
`define PDSC_ST_MIRROR   3'h6
`define PDSC_SETTLE_NS   1000
`define PDSC_CLK_NS      25
`define PDSC_SETTLE_CYC  ((`PDSC_SETTLE_NS + `PDSC_CLK_NS - 1) / `PDSC_CLK_NS)
`define PDSC_CNT_W       6
`define PDSC_NWORDS_W    14
`define PDSC_NWORDS_RST  14'h0000
`define PDSC_RAD_KEEP_W  11
`define PDSC_RR_N        4
`define PDSC_MODE_ACTIVE 2'h0
`define PDSC_MODE_SLEEP  2'h1
`define PDSC_MODE_EXT    2'h2
`define PDSC_MODE_DEEP   2'h3
`endif

// file: pdsc_keep_reg.v
// Retained register that survives domain power down
`timescale 1ns/10ps
module pdsc_keep_reg #(
  parameter W = 8
) (
  input  wire         i_ref_clk,
  input  wire         i_rstn,
  input  wire         i_ce,
  input  wire         i_wr,
  input  wire [W-1:0] i_wdata,
  output wire [W-1:0] o_rdata
);
  reg [W-1:0] data_ff;
  always @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      data_ff <= {W{1'b0}};
    end else if (i_ce && i_wr) begin
      data_ff <= i_wdata;
    end
  end
  assign o_rdata = data_ff;
endmodule // pdsc_keep_reg

// file: pdsc_checker.sv
// Assertion checker for the power domain and sleep controller
`timescale 1ns/10ps
module pdsc_checker (
  input wire        i_ref_clk,
  input wire        i_rstn,
  input wire        i_ce,
  input wire        i_core_sleeping,
  input wire        i_per_en,
  input wire        i_nwords_wr,
  input wire [13:0] i_nwords_wdata,
  input wire        o_always_on_domain,
  input wire        o_system_domain,
  input wire        o_debug_domain,
  input wire        o_peripheral_domain,
  input wire        o_system_ram_domain,
  input wire        o_iso,
  input wire        o_sysram_access_en,
  input wire        o_analog_en,
  input wire        o_periph_regs_clear,
  input wire        o_mirror_start,
  input wire [13:0] o_mirror_word_count,
  input wire        o_hw_reset,
  input wire [1:0]  o_mode
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);
  sequence s_quiet;
    !i_core_sleeping [*4];
  endsequence
  sequence s_gate;
    ##41 $fell(o_system_domain);
  endsequence
  AST_AON: assert property (o_always_on_domain)
    else $error("always-on domain dropped");
  AST_PER: assert property (o_peripheral_domain == i_per_en &&
    o_periph_regs_clear == !i_per_en)
    else $error("peripheral domain not following enable");
  AST_ISO: assert property (!o_system_domain |-> o_iso)
    else $error("system domain off without isolation");
  AST_GATE: assert property (o_debug_domain == o_system_domain && o_analog_en == o_system_domain)
    else $error("debug or analog not gated with system");
  AST_SRAM: assert property (!o_system_ram_domain |-> o_mode == 2'h3 && !o_system_domain)
    else $error("system ram off outside deep sleep");
  AST_BLOCK: assert property (o_iso |-> !o_sysram_access_en)
    else $error("system ram reachable while isolated");
  AST_SETTLE: assert property ($rose(o_iso) |-> s_gate)
    else $error("gating not one settle time after isolation");
  AST_ENTRY: assert property (s_quiet |=> !$rose(o_iso))
    else $error("gated sleep entered without core waiting");
  AST_KEEP: assert property (o_mirror_word_count ==
    $past((i_ce && i_nwords_wr) ? i_nwords_wdata : o_mirror_word_count))
    else $error("word count lost or not written");
  AST_RST: assert property (o_hw_reset |=> !o_hw_reset)
    else $error("hardware reset longer than one cycle");
  AST_MIRROR: assert property (o_mirror_start && i_ce |=> !o_iso && !o_sysram_access_en)
    else $error("mirror started without access block");
endmodule // pdsc_checker
bind pdsc_power_ctrl pdsc_checker u_pdsc_checker (.*);

// file: pdsc_core_model.sv
// Model of the core requesting sleep and waking up
`timescale 1ns/10ps
module pdsc_core_model (
  input  wire i_ref_clk,
  output reg  o_sleep_deep_bit,
  output reg  o_core_sleeping,
  output reg  o_wake_irq,
  output reg  o_retain_system_ram
);
  initial {o_sleep_deep_bit, o_core_sleeping, o_wake_irq, o_retain_system_ram} = 4'h0;
  task sleep_req(input r);
    begin
      @(posedge i_ref_clk) o_retain_system_ram <= r;
      @(posedge i_ref_clk) o_sleep_deep_bit <= 1'b1;
      @(posedge i_ref_clk) o_core_sleeping <= 1'b1;
    end
  endtask
  task idle_req;
    begin
      @(posedge i_ref_clk) o_core_sleeping <= 1'b1;
    end
  endtask
  task wake_req;
    begin
      @(posedge i_ref_clk) o_wake_irq <= 1'b1;
      repeat (3) @(posedge i_ref_clk);
      {o_wake_irq, o_core_sleeping, o_sleep_deep_bit} <= 3'h0;
    end
  endtask
endmodule // pdsc_core_model

// file: tb_top.sv
// Self-checking bench for the power domain and sleep controller
`timescale 1ns/10ps
`include "pdsc_consts.vh"
module tb_top;
  reg         i_ref_clk, i_rstn, i_ce, i_per_en, i_rad_en, i_mirror_done, i_reset_after_wake;
  reg         i_nwords_wr, i_rad_keep_wr, i_freeze_wr, i_emap_wr, i_freeze_wdata, i_emap_wdata;
  reg  [3:0]  i_rr_en;
  reg  [13:0] i_nwords_wdata, e_nw;
  reg  [10:0] i_rad_keep_wdata, e_rk;
  reg         e_fz, e_em, ms, hr;
  wire        i_sleep_deep_bit, i_core_sleeping, i_wake_irq, i_retain_system_ram;
  wire        o_always_on_domain, o_system_domain, o_peripheral_domain, o_debug_domain;
  wire        o_radio_domain, o_system_ram_domain, o_iso, o_sysram_access_en, o_analog_en;
  wire        o_periph_regs_clear, o_mirror_start, o_debug_freeze_enable;
  wire        o_exchange_memory_map, o_hw_reset;
  wire [3:0]  o_retention_ram_domains;
  wire [13:0] o_mirror_word_count;
  wire [10:0] o_radio_control_two;
  wire [1:0]  o_mode;
  integer     miscompares, checked, cyc, i, k;
  pdsc_power_ctrl u_pdsc_power_ctrl (.*);
  pdsc_core_model u_pdsc_core_model (.i_ref_clk(i_ref_clk), .o_sleep_deep_bit(i_sleep_deep_bit),
    .o_core_sleeping(i_core_sleeping), .o_wake_irq(i_wake_irq),
    .o_retain_system_ram(i_retain_system_ram));
  function [1:0] exp_mode(input r);
    exp_mode = r ? `PDSC_MODE_EXT : `PDSC_MODE_DEEP;
  endfunction
  task chk(input [13:0] g, input [13:0] e);
    begin
      checked = checked + 1;
      if (g !== e) begin
        miscompares = miscompares + 1;
        $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  task end_of_test;
    begin
      $display("checked=%0d miscompares=%0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  initial begin
    i_ref_clk = 1'b0;
    forever #12.5 i_ref_clk = ~i_ref_clk;
  end
  always @(posedge i_ref_clk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      miscompares = miscompares + 1;
      end_of_test;
    end
  end
  initial begin
    {i_rstn, i_per_en, i_rad_en, i_mirror_done, i_reset_after_wake, i_rr_en} = 9'h0;
    {i_nwords_wr, i_rad_keep_wr, i_freeze_wr, i_emap_wr, i_freeze_wdata, i_emap_wdata} = 6'h0;
    {i_nwords_wdata, i_rad_keep_wdata, e_nw, e_rk, e_fz, e_em} = 52'h0;
    i_ce = 1'b1;
    miscompares = 0;
    checked = 0;
    cyc = 0;
    k = $urandom(32'h205da05d);
    repeat (12) @(posedge i_ref_clk);
    i_rstn <= 1'b1;
    for (i = 0; i < 41; i = i + 1) begin
      @(posedge i_ref_clk);
      if (i_ce && i_nwords_wr) e_nw = i_nwords_wdata;
      if (i_ce && i_rad_keep_wr) e_rk = i_rad_keep_wdata;
      if (i_ce && i_freeze_wr) e_fz = i_freeze_wdata;
      if (i_ce && i_emap_wr) e_em = i_emap_wdata;
      {i_nwords_wr, i_rad_keep_wr, i_freeze_wr, i_emap_wr} <= (i < 40) ? $urandom : 0;
      i_ce <= (i < 40) ? (($urandom % 4) != 0) : 1'b1;
      {i_nwords_wdata, i_rad_keep_wdata, i_freeze_wdata, i_emap_wdata} <= $urandom;
      {i_per_en, i_rad_en, i_rr_en} <= $urandom;
      #1 chk(o_mirror_word_count, e_nw);
      chk({o_radio_control_two, o_debug_freeze_enable, o_exchange_memory_map}, {e_rk, e_fz, e_em});
      chk({o_radio_domain, o_retention_ram_domains}, {i_rad_en, i_rr_en});
    end
    u_pdsc_core_model.idle_req;
    repeat (4) @(posedge i_ref_clk);
    #1 chk({o_mode, o_system_domain, o_iso}, {`PDSC_MODE_SLEEP, 2'h2});
    u_pdsc_core_model.wake_req;
    for (i = 0; i < 4; i = i + 1) begin
      @(posedge i_ref_clk);
      {i_per_en, i_rad_en, i_rr_en} <= $urandom;
      i_reset_after_wake <= i[1];
      u_pdsc_core_model.sleep_req(i[0]);
      for (k = 0; k < 200 && o_system_domain !== 1'b0; k = k + 1) @(posedge i_ref_clk) #1;
      chk(o_mode, exp_mode(i[0]));
      chk(o_system_ram_domain, i[0]);
      chk({o_debug_domain, o_analog_en, o_iso, o_sysram_access_en}, 4'h2);
      chk(o_mirror_word_count, e_nw);
      chk({o_radio_control_two, o_debug_freeze_enable, o_exchange_memory_map}, {e_rk, e_fz, e_em});
      repeat (`PDSC_SETTLE_CYC + 4) @(posedge i_ref_clk);
      #1 chk({o_system_domain, o_iso}, 2'h1);
      u_pdsc_core_model.wake_req;
      {ms, hr} = 2'h0;
      for (k = 0; k < 120; k = k + 1) begin
        @(posedge i_ref_clk) #1 ms = ms | o_mirror_start;
        hr = hr | o_hw_reset;
      end
      chk({ms, hr}, {~i[0] & ~i[1], i[1]});
      @(posedge i_ref_clk) i_mirror_done <= 1'b1;
      @(posedge i_ref_clk) i_mirror_done <= 1'b0;
      repeat (2) @(posedge i_ref_clk);
      #1 chk({o_mode, o_system_domain, o_sysram_access_en}, 4'h3);
    end
    end_of_test;
  end
endmodule // tb_top
